// File: rtl/ssr_pkg.sv
// Functional notes
// - request is 1-3 chars plus end character
// - reset sequence is one bell, code 7
// - host may replace request character sequence
// - no serial poll; host reads status bytes
// - main mask selects bits raising request
// - enabled overload bits set internal-change bit
// - nonzero error mask propagates errors to error bit
// - response message sets bit 7, maskable
// - enabled new bit sets flag, sends sequence
// - syntax error writes code 11
// - no second sequence while request pending
// - main status byte accumulates until read
// - reading main status byte clears it
// - channel one overload sets its state bit
// - request flag needs no mask enable
// - semantic error writes code 40
// - only most recent error code kept
package ssr_pkg;
	localparam int unsigned ADDR_W = 6;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MAIN_STATUS = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_MAIN_MASK   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_ISTATE      = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_ISTATE_MASK = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_ERR_CODE    = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_ERR_MASK    = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_REQ_SEQ     = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_SER_CONF    = 6'h1c;
	// main status byte bit positions
	localparam int unsigned MSB_RESP = 7;
	localparam int unsigned MSB_REQ  = 6;
	localparam int unsigned MSB_ERR  = 5;
	localparam int unsigned MSB_CHG  = 3;
	// internal state byte bit positions
	localparam int unsigned IST_OVL1 = 1;
	localparam int unsigned IST_OVL2 = 2;
	// request sequence register layout
	localparam int unsigned SEQ_LEN_LSB = 24;
	localparam int unsigned SEQ_LEN_W   = 2;
	localparam int unsigned SEQ_MAX     = 3;
	localparam logic [SEQ_LEN_W-1:0] SEQ_LEN_MIN = 2'h1;
	localparam logic [SEQ_LEN_W-1:0] SEQ_LEN_MAX = 2'h3;
	// reset values and codes
	localparam logic [7:0] BELL_CHAR    = 8'h07;
	localparam logic [7:0] CR_CHAR      = 8'h0d;
	localparam logic [7:0] ERR_SYNTAX   = 8'h0b;
	localparam logic [7:0] ERR_SEMANTIC = 8'h28;
	localparam logic [7:0] ZERO_BYTE    = 8'h00;
endpackage

// File: rtl/ssr_seq_if.sv
`timescale 1ns/1ns
interface ssr_seq_if;
	logic        start;
	logic [1:0]  len;
	logic [23:0] chars;
	logic [7:0]  end_char;
	logic        busy;
	modport ctl (output start, output len, output chars, output end_char, input busy);
	modport seq (input start, input len, input chars, input end_char, output busy);
endinterface

// File: rtl/ssr_sync.sv
`timescale 1ns/1ns
module ssr_sync #(
	parameter int unsigned W = 2
) (
	// clocking
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change is accepted only once two later stages agree
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				q[i] <= 1'b0;
			end else if (ce && (s2[i] == s3[i])) begin
				q[i] <= s3[i];
			end
		end
	end
endmodule // ssr_sync

// File: rtl/ssr_tx_seq.sv
`timescale 1ns/1ns
module ssr_tx_seq (
	// clocking
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// control
	ssr_seq_if.seq          sq,
	// character stream
	output logic      [7:0] tx_data,
	output logic            tx_valid,
	input  wire logic       tx_ready
);
	typedef enum logic [1:0] {SSR_IDLE, SSR_CHAR, SSR_END} ssr_tx_state_t;
	ssr_tx_state_t state;
	logic [23:0]   chars;
	logic [7:0]    end_char;
	logic [1:0]    left;
	logic          pend;

	assign sq.busy = (state != SSR_IDLE) || pend;

	// a start arriving mid-sequence is held so it is sent afterwards
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pend <= 1'b0;
		end else if (ce) begin
			if (sq.start && state != SSR_IDLE) begin
				pend <= 1'b1;
			end else if (state == SSR_IDLE) begin
				pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state    <= SSR_IDLE;
			chars    <= '0;
			end_char <= ssr_pkg::CR_CHAR;
			left     <= '0;
			tx_data  <= ssr_pkg::ZERO_BYTE;
			tx_valid <= 1'b0;
		end else if (ce) begin
			unique case (state)
				SSR_IDLE: begin
					if (sq.start || pend) begin
						// sequence is latched so a rewrite cannot tear it
						chars    <= {8'h00, sq.chars[23:8]};
						end_char <= sq.end_char;
						left     <= sq.len - 2'h1;
						tx_data  <= sq.chars[7:0];
						tx_valid <= 1'b1;
						state    <= SSR_CHAR;
					end
				end
				SSR_CHAR: begin
					if (tx_ready) begin
						if (left != 2'h0) begin
							tx_data <= chars[7:0];
							chars   <= {8'h00, chars[23:8]};
							left    <= left - 2'h1;
						end else begin
							tx_data <= end_char;
							state   <= SSR_END;
						end
					end
				end
				SSR_END: begin
					if (tx_ready) begin
						tx_valid <= 1'b0;
						state    <= SSR_IDLE;
					end
				end
				default: state <= SSR_IDLE;
			endcase
		end
	end
endmodule // ssr_tx_seq

// File: rtl/ssr_top.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module ssr_top (
	// clocking
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ssr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// overload pins, asynchronous
	input  wire logic                       ovl_one_pin,
	input  wire logic                       ovl_two_pin,
	// events from the command parser, one-cycle pulses
	input  wire logic                       resp_msg_evt,
	input  wire logic                       syntax_err_evt,
	input  wire logic                       semantic_err_evt,
	// serial character stream toward the transmitter
	output logic      [7:0]                 tx_data,
	output logic                            tx_valid,
	input  wire logic                       tx_ready,
	// status
	output logic                            request_pending_flag
);
	ssr_seq_if sq ();

	logic [7:0]  main_status_byte;
	logic [7:0]  main_mask;
	logic [7:0]  internal_state_byte;
	logic [7:0]  istate_mask;
	logic [7:0]  error_code_byte;
	logic [7:0]  err_mask;
	logic [1:0]  seq_len;
	logic [23:0] seq_chars;
	logic [7:0]  end_char;
	logic [1:0]  ovl_sync;
	logic [1:0]  ovl_prev;
	logic        input_one_overload_flag;

	logic        acc_wait;
	logic        acc_done;
	logic        wr_done;
	logic        rd_done;
	logic        hit;
	logic [31:0] rd_mux;
	logic [7:0]  ist_set;
	logic [7:0]  msb_set;
	logic        err_evt;
	logic [7:0]  next_err_code;
	logic        next_req;
	logic [1:0]  wr_len;
	logic        main_clr;

	ssr_sync #(
		.W (2)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.d       ({ovl_two_pin, ovl_one_pin}),
		.q       (ovl_sync)
	);

	ssr_tx_seq u_seq (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.sq       (sq.seq),
		.tx_data  (tx_data),
		.tx_valid (tx_valid),
		.tx_ready (tx_ready)
	);

	// apb: one wait state, so read data is registered before the access ends
	assign acc_wait = psel && penable && !pready;
	assign acc_done = psel && penable && pready;
	assign wr_done  = acc_done && pwrite && !pslverr;
	assign rd_done  = acc_done && !pwrite && !pslverr;
	assign wr_len   = pwdata[ssr_pkg::SEQ_LEN_LSB +: ssr_pkg::SEQ_LEN_W];

	always_comb begin
		hit    = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			ssr_pkg::OFS_MAIN_STATUS: rd_mux[7:0] = main_status_byte;
			ssr_pkg::OFS_MAIN_MASK:   rd_mux[7:0] = main_mask;
			ssr_pkg::OFS_ISTATE:      rd_mux[7:0] = internal_state_byte;
			ssr_pkg::OFS_ISTATE_MASK: rd_mux[7:0] = istate_mask;
			ssr_pkg::OFS_ERR_CODE:    rd_mux[7:0] = error_code_byte;
			ssr_pkg::OFS_ERR_MASK:    rd_mux[7:0] = err_mask;
			ssr_pkg::OFS_REQ_SEQ:     rd_mux = {6'h00, seq_len, seq_chars};
			ssr_pkg::OFS_SER_CONF:    rd_mux[7:0] = end_char;
			default:                  hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready <= acc_wait;
			if (acc_wait) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !hit;
			end
		end
	end

	// mask registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			main_mask   <= ssr_pkg::ZERO_BYTE;
			istate_mask <= ssr_pkg::ZERO_BYTE;
			err_mask    <= ssr_pkg::ZERO_BYTE;
		end else if (ce && wr_done) begin
			if (paddr == ssr_pkg::OFS_MAIN_MASK) begin
				main_mask <= pwdata[7:0];
			end
			if (paddr == ssr_pkg::OFS_ISTATE_MASK) begin
				istate_mask <= pwdata[7:0];
			end
			if (paddr == ssr_pkg::OFS_ERR_MASK) begin
				err_mask <= pwdata[7:0];
			end
		end
	end

	// request sequence and end character; an illegal length is ignored
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			seq_len   <= ssr_pkg::SEQ_LEN_MIN;
			seq_chars <= {16'h0000, ssr_pkg::BELL_CHAR};
			end_char  <= ssr_pkg::CR_CHAR;
		end else if (ce && wr_done) begin
			if (paddr == ssr_pkg::OFS_REQ_SEQ && wr_len >= ssr_pkg::SEQ_LEN_MIN) begin
				seq_len   <= wr_len;
				seq_chars <= pwdata[23:0];
			end
			if (paddr == ssr_pkg::OFS_SER_CONF) begin
				end_char <= pwdata[7:0];
			end
		end
	end

	// overload detection on rising edges of the filtered pins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ovl_prev <= '0;
		end else if (ce) begin
			ovl_prev <= ovl_sync;
		end
	end

	always_comb begin
		ist_set = '0;
		ist_set[ssr_pkg::IST_OVL1] = ovl_sync[0] && !ovl_prev[0];
		ist_set[ssr_pkg::IST_OVL2] = ovl_sync[1] && !ovl_prev[1];
	end

	assign input_one_overload_flag = internal_state_byte[ssr_pkg::IST_OVL1];

	// read clears only the bits that were returned, new events win
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			internal_state_byte <= ssr_pkg::ZERO_BYTE;
		end else if (ce) begin
			if (rd_done && paddr == ssr_pkg::OFS_ISTATE) begin
				internal_state_byte <= (internal_state_byte & ~prdata[7:0]) | ist_set;
			end else begin
				internal_state_byte <= internal_state_byte | ist_set;
			end
		end
	end

	// error byte: semantic wins a tie, last error overwrites older ones
	assign err_evt = syntax_err_evt || semantic_err_evt;

	always_comb begin
		next_err_code = error_code_byte;
		if (semantic_err_evt) begin
			next_err_code = ssr_pkg::ERR_SEMANTIC;
		end else if (syntax_err_evt) begin
			next_err_code = ssr_pkg::ERR_SYNTAX;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			error_code_byte <= ssr_pkg::ZERO_BYTE;
		end else if (ce) begin
			if (err_evt) begin
				error_code_byte <= next_err_code;
			end else if (rd_done && paddr == ssr_pkg::OFS_ERR_CODE) begin
				error_code_byte <= ssr_pkg::ZERO_BYTE;
			end
		end
	end

	// condition bits entering the main status byte this cycle
	always_comb begin
		msb_set = '0;
		msb_set[ssr_pkg::MSB_RESP] = resp_msg_evt;
		msb_set[ssr_pkg::MSB_ERR]  = err_evt && (err_mask != 8'h00);
		msb_set[ssr_pkg::MSB_CHG]  = (ist_set & istate_mask) != 8'h00;
		// the request bit itself is never masked
		next_req = (msb_set & main_mask) != 8'h00;
		msb_set[ssr_pkg::MSB_REQ] = next_req;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			main_status_byte <= ssr_pkg::ZERO_BYTE;
		end else if (ce) begin
			if (rd_done && paddr == ssr_pkg::OFS_MAIN_STATUS) begin
				main_status_byte <= (main_status_byte & ~prdata[7:0]) | msb_set;
			end else begin
				main_status_byte <= main_status_byte | msb_set;
			end
		end
	end

	assign main_clr    = rd_done && paddr == ssr_pkg::OFS_MAIN_STATUS;
	// a sequence starts when the request bit goes from clear to set; a new event in
	// the cycle whose read clears the bit must start one too, as the set wins there
	assign sq.start    = ce && next_req && !(main_status_byte[ssr_pkg::MSB_REQ]
		&& !(main_clr && prdata[ssr_pkg::MSB_REQ]));
	assign sq.len      = seq_len;
	assign sq.chars    = seq_chars;
	assign sq.end_char = end_char;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			request_pending_flag <= 1'b0;
		end else if (ce) begin
			if (rd_done && paddr == ssr_pkg::OFS_MAIN_STATUS) begin
				request_pending_flag <= next_req || (main_status_byte[ssr_pkg::MSB_REQ]
					&& !prdata[ssr_pkg::MSB_REQ]);
			end else begin
				request_pending_flag <= main_status_byte[ssr_pkg::MSB_REQ] || next_req;
			end
		end
	end
endmodule // ssr_top

// File: testbench/ssr_top_asserts.sv
`timescale 1ns/1ns
module ssr_top_asserts (
	// clocking
	input wire logic                       sys_clk,
	input wire logic                       rst_n,
	input wire logic                       ce,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [ssr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// events
	input wire logic                       ovl_one_pin,
	input wire logic                       ovl_two_pin,
	input wire logic                       resp_msg_evt,
	input wire logic                       syntax_err_evt,
	input wire logic                       semantic_err_evt,
	// stream
	input wire logic [7:0]                 tx_data,
	input wire logic                       tx_valid,
	input wire logic                       tx_ready,
	input wire logic                       request_pending_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire rd_main = psel && penable && pready && !pwrite && paddr == ssr_pkg::OFS_MAIN_STATUS;
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	pready_cause_a: assert property ($rose(pready) |-> $past(psel && penable) && psel && penable)
		else $error("pready without access");
	unmapped_err_a: assert property (pready && paddr > ssr_pkg::OFS_SER_CONF |-> pslverr)
		else $error("no slave error");
	mapped_ok_a: assert property (pready && paddr <= ssr_pkg::OFS_SER_CONF && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("spurious slave error");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("character dropped");
	req_tx_a: assert property ($rose(request_pending_flag) |-> ##[0:1] tx_valid)
		else $error("request without sequence");
	flag_clear_a: assert property ($fell(request_pending_flag) |-> $past(rd_main))
		else $error("flag cleared without read");
	main_bits_a: assert property (rd_main |-> prdata[31:8] == 24'h0 && prdata[4] == 1'h0
		&& prdata[2:0] == 3'h0) else $error("unused status bit set");
endmodule // ssr_top_asserts
bind ssr_top ssr_top_asserts ssr_top_asserts_i (
	.sys_clk              (sys_clk),
	.rst_n                (rst_n),
	.ce                   (ce),
	.psel                 (psel),
	.penable              (penable),
	.pwrite               (pwrite),
	.paddr                (paddr),
	.pwdata               (pwdata),
	.prdata               (prdata),
	.pready               (pready),
	.pslverr              (pslverr),
	.ovl_one_pin          (ovl_one_pin),
	.ovl_two_pin          (ovl_two_pin),
	.resp_msg_evt         (resp_msg_evt),
	.syntax_err_evt       (syntax_err_evt),
	.semantic_err_evt     (semantic_err_evt),
	.tx_data              (tx_data),
	.tx_valid             (tx_valid),
	.tx_ready             (tx_ready),
	.request_pending_flag (request_pending_flag)
);

// File: testbench/ssr_host.sv
`timescale 1ns/1ns
module ssr_host (
	// clocking
	input wire logic       sys_clk,
	// stream
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	output logic           tx_ready,
	// test control
	input wire logic       stall
);
	logic [7:0] rx_q [$];
	// no request line exists, so the host only sees characters
	assign tx_ready = !stall;
	always @(posedge sys_clk) begin
		if (tx_valid && tx_ready) begin
			rx_q.push_back(tx_data);
		end
	end
endmodule // ssr_host

// File: testbench/ssr_top_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module ssr_top_test;
	localparam logic [7:0] ALL = (8'h1 << ssr_pkg::MSB_RESP) | (8'h1 << ssr_pkg::MSB_REQ)
		| (8'h1 << ssr_pkg::MSB_ERR) | (8'h1 << ssr_pkg::MSB_CHG);
	localparam logic [7:0] SEQ [4] = '{8'h61, 8'h62, 8'h63, 8'h0a};
	logic                       sys_clk = 1'h0;
	logic                       rst_n = 1'h0;
	logic                       psel = 1'h0;
	logic                       penable = 1'h0;
	logic                       pwrite = 1'h0;
	logic [ssr_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0]                pwdata = '0;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic                       ovl_one = 1'h0;
	logic                       ovl_two = 1'h0;
	logic                       resp = 1'h0;
	logic                       syn = 1'h0;
	logic                       sem = 1'h0;
	logic [7:0]                 tx_data;
	logic                       tx_valid;
	logic                       tx_ready;
	logic                       flag;
	logic                       stall = 1'h0;
	logic                       last_err;
	logic [31:0]                rd;
	int                         error_cnt = 0;
	int                         comparisons = 0;
	always #25 sys_clk = ~sys_clk;
	ssr_top ssr_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ovl_one_pin(ovl_one), .ovl_two_pin(ovl_two),
		.resp_msg_evt(resp), .syntax_err_evt(syn), .semantic_err_evt(sem), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .request_pending_flag(flag));
	ssr_host ssr_host_i (.sys_clk(sys_clk), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .stall(stall));
	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang;
		error_cnt++;
		$display("ERROR %0t: wait timed out", $time);
		print_verdict;
	endtask
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		// read right after the edge, these are the values that edge sampled
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) hang;
		rd = prdata;
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// one-cycle pulse on {response, syntax, semantic}
	task automatic ev(input logic [2:0] m);
		@(posedge sys_clk);
		{resp, syn, sem} <= m;
		@(posedge sys_clk);
		{resp, syn, sem} <= 3'h0;
	endtask
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (ssr_host_i.rx_q.size() < n && k < 200) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 200) hang;
	endtask
	task automatic t_defaults;
		rdchk(ssr_pkg::OFS_MAIN_MASK, 32'h0);
		rdchk(ssr_pkg::OFS_REQ_SEQ, 32'h01000007);
		rdchk(ssr_pkg::OFS_SER_CONF, 32'h0000000d);
		rdchk(6'h20, 32'h0);
		`CHK(last_err, 1'h1)
	endtask
	task automatic t_masked;
		ev(3'h4);
		repeat (5) @(posedge sys_clk);
		`CHK(tx_valid, 1'h0)
		rdchk(ssr_pkg::OFS_MAIN_STATUS, 32'h80);
		rdchk(ssr_pkg::OFS_MAIN_STATUS, 32'h0);
	endtask
	task automatic t_overload;
		apb(1'h1, ssr_pkg::OFS_MAIN_MASK, 32'h28);
		apb(1'h1, ssr_pkg::OFS_ISTATE_MASK, 32'h06);
		apb(1'h1, ssr_pkg::OFS_ERR_MASK, 32'h01);
		stall <= 1'h1;
		{ovl_two, ovl_one} <= 2'h3;
		repeat (12) @(posedge sys_clk);
		stall <= 1'h0;
		wait_rx(2);
		`CHK(ssr_host_i.rx_q[0], 8'h07)
		`CHK(ssr_host_i.rx_q[1], 8'h0d)
		rdchk(ssr_pkg::OFS_ISTATE, 32'h6);
		{ovl_two, ovl_one} <= 2'h0;
	endtask
	task automatic t_accum;
		ev(3'h6);
		repeat (8) @(posedge sys_clk);
		`CHK(ssr_host_i.rx_q.size(), 2)
		rdchk(ssr_pkg::OFS_ERR_CODE, 32'h0b);
		rdchk(ssr_pkg::OFS_MAIN_STATUS, {24'h0, ALL});
		rdchk(ssr_pkg::OFS_MAIN_STATUS, 32'h0);
		`CHK(flag, 1'h0)
	endtask
	task automatic t_errs;
		apb(1'h1, ssr_pkg::OFS_REQ_SEQ, 32'h03636261);
		apb(1'h1, ssr_pkg::OFS_SER_CONF, 32'h0a);
		stall <= 1'h1;
		ev(3'h2);
		ev(3'h1);
		rdchk(ssr_pkg::OFS_ERR_CODE, 32'h28);
		stall <= 1'h0;
		wait_rx(6);
		for (int i = 0; i < 4; i++) `CHK(ssr_host_i.rx_q[i + 2], SEQ[i])
		rdchk(ssr_pkg::OFS_MAIN_STATUS, 32'h60);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		t_defaults;
		t_masked;
		t_overload;
		t_accum;
		t_errs;
		print_verdict;
	end
endmodule // ssr_top_test
